//--- logic/spgc_pkg.sv
// Constants for the serial-port GPIO block with codec reset sequencer.
package spgc_pkg;
	localparam int          PORT_W        = 24;
	localparam int          PINS          = 6;
	localparam int          ADR_W         = 3;
	localparam logic [2:0]  A_C_FUNC      = 3'h0;
	localparam logic [2:0]  A_D_FUNC      = 3'h1;
	localparam logic [2:0]  A_C_DIR       = 3'h2;
	localparam logic [2:0]  A_D_DIR       = 3'h3;
	localparam logic [2:0]  A_C_DATA      = 3'h4;
	localparam logic [2:0]  A_D_DATA      = 3'h5;
	localparam logic [2:0]  A_SEQ         = 3'h6;
	localparam int          BIT_RESET     = 0;
	localparam int          BIT_CSEL      = 0;
	localparam int          BIT_SEQ_GO    = 0;
	localparam int          BIT_SEQ_BUSY  = 1;
	localparam int          BIT_SEQ_DONE  = 2;
	localparam logic [5:0]  FUNC_RST      = 6'h00;
	localparam logic [5:0]  DIR_RST       = 6'h00;
	localparam int          CLK_MHZ       = 250;
	localparam int          HOLD_NS       = 1000;
	localparam int          POST_NS       = 500;
	localparam int          HOLD_CYC      = (HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int          POST_CYC      = (POST_NS * CLK_MHZ + 999) / 1000;
	localparam int          CNT_W         = 16;
	typedef enum logic [1:0] {SQ_IDLE, SQ_HOLD, SQ_POST} spgc_seq_t;
endpackage : spgc_pkg

//--- logic/spgc_top.sv
// Serial-port pin sharing, GPIO registers and codec reset sequencer.
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/1ns
module spgc_top #(
	parameter int HOLD_CYCLES = spgc_pkg::HOLD_CYC,
	parameter int POST_CYCLES = spgc_pkg::POST_CYC
) (
	// Clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	// Wishbone slave
	input  wire logic                       cyc_i,
	input  wire logic                       stb_i,
	input  wire logic                       we_i,
	input  wire logic [31:0]                adr_i,
	input  wire logic [3:0]                 sel_i,
	input  wire logic [31:0]                dat_i,
	output logic      [31:0]                dat_o,
	output logic                            ack_o,
	// Port C pins
	input  wire logic [spgc_pkg::PINS-1:0]  pc_pin_i,
	output logic      [spgc_pkg::PINS-1:0]  pc_pin_o,
	output logic      [spgc_pkg::PINS-1:0]  pc_pin_oe_o,
	// Port D pins
	input  wire logic [spgc_pkg::PINS-1:0]  pd_pin_i,
	output logic      [spgc_pkg::PINS-1:0]  pd_pin_o,
	output logic      [spgc_pkg::PINS-1:0]  pd_pin_oe_o,
	// Serial port function side
	input  wire logic [spgc_pkg::PINS-1:0]  pc_ser_o_i,
	input  wire logic [spgc_pkg::PINS-1:0]  pc_ser_oe_i,
	output logic      [spgc_pkg::PINS-1:0]  pc_ser_i_o,
	input  wire logic [spgc_pkg::PINS-1:0]  pd_ser_o_i,
	input  wire logic [spgc_pkg::PINS-1:0]  pd_ser_oe_i,
	output logic      [spgc_pkg::PINS-1:0]  pd_ser_i_o
);
	localparam int N = spgc_pkg::PINS;

	logic [N-1:0]                 c_func_r;
	logic [N-1:0]                 d_func_r;
	logic [N-1:0]                 c_dir_r;
	logic [N-1:0]                 d_dir_r;
	logic [N-1:0]                 c_data_r;
	logic [N-1:0]                 d_data_r;
	logic [N-1:0]                 c_data_nxt;
	logic [N-1:0]                 d_data_nxt;
	logic                         seq_done_r;
	logic [spgc_pkg::CNT_W-1:0]   cnt_r;
	spgc_pkg::spgc_seq_t          seq_r;

	// Bus decode
	wire                          req     = cyc_i & stb_i & ~ack_o;
	wire                          wr      = req & we_i & sel_i[0];
	wire [spgc_pkg::ADR_W-1:0]    idx     = adr_i[spgc_pkg::ADR_W+1:2];
	wire                          hi_zero = (adr_i[31:spgc_pkg::ADR_W+2] == 27'h0000000);
	wire                          wr_cf   = wr & hi_zero & (idx == spgc_pkg::A_C_FUNC);
	wire                          wr_df   = wr & hi_zero & (idx == spgc_pkg::A_D_FUNC);
	wire                          wr_cd   = wr & hi_zero & (idx == spgc_pkg::A_C_DIR);
	wire                          wr_dd   = wr & hi_zero & (idx == spgc_pkg::A_D_DIR);
	wire                          wr_ca   = wr & hi_zero & (idx == spgc_pkg::A_C_DATA);
	wire                          wr_da   = wr & hi_zero & (idx == spgc_pkg::A_D_DATA);
	wire                          go      = wr & hi_zero & (idx == spgc_pkg::A_SEQ)
	                                        & dat_i[spgc_pkg::BIT_SEQ_GO]
	                                        & (seq_r == spgc_pkg::SQ_IDLE);

	// Pin direction per bit: serial owns pin, else direction bit decides
	wire [N-1:0] c_gpio_out = ~c_func_r & c_dir_r;
	wire [N-1:0] d_gpio_out = ~d_func_r & d_dir_r;

	// Read data: input pins show their level, output pins the stored bit
	wire [N-1:0] c_rd = (c_data_r & c_gpio_out) | (pc_pin_i & ~c_gpio_out);
	wire [N-1:0] d_rd = (d_data_r & d_gpio_out) | (pd_pin_i & ~d_gpio_out);

	logic [N-1:0] rd_sel;
	always_comb begin
		rd_sel = '0;
		unique case (idx)
			spgc_pkg::A_C_FUNC: rd_sel = c_func_r;
			spgc_pkg::A_D_FUNC: rd_sel = d_func_r;
			spgc_pkg::A_C_DIR:  rd_sel = c_dir_r;
			spgc_pkg::A_D_DIR:  rd_sel = d_dir_r;
			spgc_pkg::A_C_DATA: rd_sel = c_rd;
			spgc_pkg::A_D_DATA: rd_sel = d_rd;
			spgc_pkg::A_SEQ: begin
				rd_sel[spgc_pkg::BIT_SEQ_BUSY] = (seq_r != spgc_pkg::SQ_IDLE);
				rd_sel[spgc_pkg::BIT_SEQ_DONE] = seq_done_r;
			end
			default:            rd_sel = '0;
		endcase
	end
	wire [31:0] rd_word = hi_zero ? {{(32-N){1'b0}}, rd_sel} : 32'h00000000;

	// Data register next values; sequencer overrides software
	always_comb begin
		c_data_nxt = wr_ca ? dat_i[N-1:0] : c_data_r;
		d_data_nxt = wr_da ? dat_i[N-1:0] : d_data_r;
		if (go) begin
			d_data_nxt[spgc_pkg::BIT_CSEL]  = 1'b1;
			c_data_nxt[spgc_pkg::BIT_RESET] = 1'b0;
		end
		if (seq_r == spgc_pkg::SQ_HOLD && cnt_r == '0) begin
			c_data_nxt[spgc_pkg::BIT_RESET] = 1'b1;
		end
		if (seq_r != spgc_pkg::SQ_IDLE) begin
			d_data_nxt[spgc_pkg::BIT_CSEL] = 1'b1;
		end
	end

	// Data registers are not reset
	always_ff @(posedge clk_i) begin
		c_data_r <= c_data_nxt;
		d_data_r <= d_data_nxt;
	end

	// Control registers and bus answer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			c_func_r <= spgc_pkg::FUNC_RST;
			d_func_r <= spgc_pkg::FUNC_RST;
			c_dir_r  <= spgc_pkg::DIR_RST;
			d_dir_r  <= spgc_pkg::DIR_RST;
			ack_o    <= 1'b0;
			dat_o    <= 32'h00000000;
		end else begin
			if (wr_cf) c_func_r <= dat_i[N-1:0];
			if (wr_df) d_func_r <= dat_i[N-1:0];
			if (wr_cd) c_dir_r  <= dat_i[N-1:0];
			if (wr_dd) d_dir_r  <= dat_i[N-1:0];
			ack_o <= req;
			dat_o <= req ? rd_word : 32'h00000000;
		end
	end

	// Reset sequencer; chip select is left high for the transfer routine
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seq_r      <= spgc_pkg::SQ_IDLE;
			cnt_r      <= '0;
			seq_done_r <= 1'b0;
		end else begin
			unique case (seq_r)
				spgc_pkg::SQ_IDLE: if (go) begin
					seq_r      <= spgc_pkg::SQ_HOLD;
					cnt_r      <= spgc_pkg::CNT_W'(HOLD_CYCLES - 1);
					seq_done_r <= 1'b0;
				end
				spgc_pkg::SQ_HOLD: if (cnt_r == '0) begin
					seq_r <= spgc_pkg::SQ_POST;
					cnt_r <= spgc_pkg::CNT_W'(POST_CYCLES - 1);
				end else begin
					cnt_r <= cnt_r - 1'b1;
				end
				spgc_pkg::SQ_POST: if (cnt_r == '0) begin
					seq_r      <= spgc_pkg::SQ_IDLE;
					seq_done_r <= 1'b1;
				end else begin
					cnt_r <= cnt_r - 1'b1;
				end
				default: seq_r <= spgc_pkg::SQ_IDLE;
			endcase
		end
	end

	// Pin drivers: registered so outputs come straight from flip-flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_pin_o    <= '0;
			pc_pin_oe_o <= '0;
			pd_pin_o    <= '0;
			pd_pin_oe_o <= '0;
			pc_ser_i_o  <= '0;
			pd_ser_i_o  <= '0;
		end else begin
			pc_pin_o    <= (c_func_r & pc_ser_o_i) | (~c_func_r & c_data_nxt);
			pc_pin_oe_o <= (c_func_r & pc_ser_oe_i) | c_gpio_out;
			pd_pin_o    <= (d_func_r & pd_ser_o_i) | (~d_func_r & d_data_nxt);
			pd_pin_oe_o <= (d_func_r & pd_ser_oe_i) | d_gpio_out;
			pc_ser_i_o  <= pc_pin_i & c_func_r;
			pd_ser_i_o  <= pd_pin_i & d_func_r;
		end
	end
endmodule : spgc_top

//--- test/spgc_top_asserts.sv
// Port-level assertions for spgc_top.
`timescale 1ns/1ns
module spgc_top_asserts (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [31:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic [5:0]  pc_pin_oe_o,
	input wire logic [5:0]  pd_pin_oe_o,
	input wire logic [5:0]  pc_ser_oe_i,
	input wire logic [5:0]  pd_ser_oe_i
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack1; ack_o |=> !ack_o; endproperty
	a_ack1: assert property (p_ack1) else $error("ack too long");
	property p_ack_req; ack_o |-> $past(cyc_i) && $past(stb_i); endproperty
	a_ack_req: assert property (p_ack_req) else $error("ack without request");
	property p_idle; !ack_o |-> dat_o == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("data without ack");
	property p_upper; ack_o |-> dat_o[31:6] == 26'h0; endproperty
	a_upper: assert property (p_upper) else $error("upper bits set");
	property p_far;
		ack_o && !$past(we_i) && $past(adr_i[31:5]) != 27'h0 |-> dat_o == 32'h0;
	endproperty
	a_far: assert property (p_far) else $error("unmapped read not zero");
	property p_rst; $fell(rst_i) |-> pc_pin_oe_o == 6'h00 && pd_pin_oe_o == 6'h00; endproperty
	a_rst: assert property (p_rst) else $error("pins driven after reset");
	// Enables move one edge after the acked write or serial enable change
	property p_oe_c;
		$changed(pc_pin_oe_o) && $past(pc_ser_oe_i) == $past(pc_ser_oe_i, 2) |-> $past(ack_o);
	endproperty
	a_oe_c: assert property (p_oe_c) else $error("port c enable moved");
	property p_oe_d;
		$changed(pd_pin_oe_o) && $past(pd_ser_oe_i) == $past(pd_ser_oe_i, 2) |-> $past(ack_o);
	endproperty
	a_oe_d: assert property (p_oe_d) else $error("port d enable moved");
endmodule : spgc_top_asserts
bind spgc_top spgc_top_asserts u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o,
	.ack_o, .pc_pin_oe_o, .pd_pin_oe_o, .pc_ser_oe_i, .pd_ser_oe_i);

//--- test/spgc_codec_model.sv
// Codec side: watches its reset and chip-select lines.
`timescale 1ns/1ns
module spgc_codec_model #(
	parameter int POST = 3
) (
	input  wire logic clk_i,
	input  wire logic rst_n_line_i,
	input  wire logic cs_n_line_i,
	output int        hold_len_o,
	output logic      early_o
);
	int   low_cnt = 0;
	int   post_cnt = 0;
	logic rst_q;
	logic cs_q;
	initial early_o = 1'b0;
	initial hold_len_o = 0;
	always @(posedge clk_i) begin
		rst_q <= rst_n_line_i;
		cs_q <= cs_n_line_i;
		low_cnt <= rst_n_line_i ? 0 : low_cnt + 1;
		if (rst_n_line_i && !rst_q) hold_len_o <= low_cnt;
		post_cnt <= !rst_n_line_i ? 0 : post_cnt + 1;
		if (!cs_n_line_i && cs_q && post_cnt < POST) early_o <= 1'b1;
		if (!rst_n_line_i && !cs_n_line_i) early_o <= 1'b1;
	end
endmodule : spgc_codec_model

//--- test/tb_spgc_top.sv
// Self-checking bench for spgc_top.
`timescale 1ns/1ns
module tb_spgc_top;
	localparam int HOLD = 4;
	localparam int POST = 3;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o, expq[$];
	logic [5:0]  pc_in = 6'h00, so = 6'h00, soe = 6'h00, r, pc_o, pc_oe, pd_o, pd_oe, pc_si;
	logic        ack_o, early;
	int          hold_len, n_fail = 0, check_count = 0;
	wire  [5:0]  pc_pin = (pc_oe & pc_o) | (~pc_oe & pc_in);
	wire  [5:0]  pd_pin = (pd_oe & pd_o) | (~pd_oe & ~pc_in);
	always #2 clk_i = ~clk_i;
	spgc_top #(.HOLD_CYCLES(HOLD), .POST_CYCLES(POST)) dut (.clk_i, .rst_i, .cyc_i, .stb_i,
		.we_i, .adr_i, .sel_i(4'hF), .dat_i, .dat_o, .ack_o, .pc_pin_i(pc_pin), .pc_pin_o(pc_o),
		.pc_pin_oe_o(pc_oe), .pd_pin_i(pd_pin), .pd_pin_o(pd_o), .pd_pin_oe_o(pd_oe),
		.pc_ser_o_i(so), .pc_ser_oe_i(soe), .pc_ser_i_o(pc_si), .pd_ser_o_i(so),
		.pd_ser_oe_i(~soe), .pd_ser_i_o());
	// Codec lines are pulled up while undriven
	spgc_codec_model #(.POST(POST)) codec (.clk_i, .rst_n_line_i(pc_oe[0] ? pc_o[0] : 1'b1),
		.cs_n_line_i(pd_oe[0] ? pd_o[0] : 1'b1), .hold_len_o(hold_len), .early_o(early));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
		n = 0;
		do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
		if (ack_o !== 1'b1) begin n_fail++; report_and_stop(); end
		{cyc_i, stb_i} <= 2'h0;
	endtask : wb
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		wb(1'b1, {27'h0, a, 2'h0}, d);
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [31:0] e);
		expq.push_back(e);
		wb(1'b0, {27'h0, a, 2'h0}, 32'h0);
	endtask : rd
	always @(posedge clk_i) if (ack_o === 1'b1 && we_i === 1'b0)
		chk(dat_o, expq.size() ? expq.pop_front() : 32'hFFFFFFFF);
	initial begin repeat (5000) @(posedge clk_i); n_fail++; report_and_stop(); end
	initial begin
		void'($urandom(4));
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		pc_in <= 6'($urandom);
		r = 6'($urandom) | 6'h01;
		rd(spgc_pkg::A_C_FUNC, 32'h0);
		rd(3'h7, 32'h0);
		rd(spgc_pkg::A_C_DATA, {26'h0, pc_in});
		expq.push_back(32'h0);
		wb(1'b0, 32'h100, 32'h0);
		wr(spgc_pkg::A_C_FUNC, 32'h0);
		wr(spgc_pkg::A_C_DATA, {26'h0, r});
		wr(spgc_pkg::A_D_DATA, 32'h3F);
		wr(spgc_pkg::A_C_DIR, 32'h1);
		wr(spgc_pkg::A_D_DIR, 32'h7);
		// Enables follow the direction write one edge later
		@(negedge clk_i);
		chk({pc_oe, pd_oe, pc_o[0]}, {6'h01, 6'h07, 1'b1});
		rd(spgc_pkg::A_C_DATA, {26'h0, pc_in[5:1], 1'b1});
		wr(spgc_pkg::A_SEQ, 32'h1);
		chk({pd_o[0], pc_o[0]}, 2'h2);
		// Software tries to select the codec mid-sequence
		wr(spgc_pkg::A_D_DATA, 32'h3E);
		chk(32'(pd_o[0]), 32'h1);
		rd(spgc_pkg::A_SEQ, 32'h2);
		repeat (HOLD + POST + 4) @(posedge clk_i);
		rd(spgc_pkg::A_SEQ, 32'h4);
		chk(32'(hold_len), 32'(HOLD));
		wr(spgc_pkg::A_D_DATA, 32'h3E);
		chk(32'(pd_o[0]), 32'h0);
		so <= 6'($urandom);
		soe <= 6'($urandom);
		wr(spgc_pkg::A_C_DIR, 32'h3F);
		wr(spgc_pkg::A_C_FUNC, 32'h3C);
		// Serial input path lags the pins by one more edge
		@(posedge clk_i);
		@(negedge clk_i);
		chk({pc_oe, pc_o & 6'h3C}, {soe & 6'h3C | 6'h03, so & 6'h3C});
		chk({pc_si, pd_oe}, {pc_pin & 6'h3C, 6'h07});
		chk(32'(early), 32'h0);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wr(spgc_pkg::A_C_DIR, 32'h1);
		rd(spgc_pkg::A_C_DATA, {26'h0, pc_in[5:1], 1'b1});
		repeat (2) @(posedge clk_i);
		report_and_stop();
	end
endmodule : tb_spgc_top
